// [core/urxb_pkg.sv]
// package: register map, field layout and encodings of the serial unit
package urxb_pkg;
    localparam int          URXB_DW       = 32;
    localparam logic [7:0]  URXB_OFS_MODE = 8'h00;
    localparam logic [7:0]  URXB_OFS_BAUD = 8'h04;
    localparam logic [7:0]  URXB_OFS_ERR  = 8'h08;
    localparam logic [7:0]  URXB_OFS_RXB  = 8'h0C;
    localparam logic [7:0]  URXB_OFS_TX   = 8'h10;
    // mode register fields
    localparam int          URXB_MODE_PWR = 7;
    localparam int          URXB_MODE_TXE = 6;
    localparam int          URXB_MODE_RXE = 5;
    localparam int          URXB_MODE_PAR = 3;
    localparam int          URXB_MODE_LEN = 2;
    localparam int          URXB_MODE_STP = 1;
    localparam logic [7:0]  URXB_MODE_RST = 8'h04;
    // baud control fields
    localparam int          URXB_BAUD_SEL = 6;
    localparam int          URXB_BAUD_DIV = 0;
    localparam logic [7:0]  URXB_BAUD_RST = 8'h08;
    localparam logic [4:0]  URXB_DIV_MIN  = 5'h08;
    // error status bits
    localparam int          URXB_ERR_PAR  = 2;
    localparam int          URXB_ERR_FRM  = 1;
    localparam int          URXB_ERR_OVR  = 0;
    localparam logic [31:0] URXB_ZERO     = 32'h0000_0000;
    typedef enum logic [1:0] {
        URXB_PAR_NONE,
        URXB_PAR_ZERO,
        URXB_PAR_ODD,
        URXB_PAR_EVEN
    } urxb_par_e;
    typedef struct packed {
        logic      power;
        logic      tx_en;
        logic      rx_en;
        urxb_par_e par;
        logic      len8;
        logic      stop2;
        logic      rsvd;
    } urxb_mode_s;
    typedef struct packed {
        logic parity;
        logic framing;
        logic overrun;
    } urxb_err_s;
endpackage

// [core/urxb_top.sv]
// serial unit: receive errors, input filter, baud generator and register slave
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - detect parity, framing, overrun faults as flags
// - raise error request when receive sets flag
// - status read returns flags, then clears them
// - parity fault on mismatch with configured odd or even parity
// - framing fault when stop sample is low
// - overrun when character ends before buffer read
// - filter output changes when two samples agree
// - receive processing lags line by three ticks
// - separate 5-bit transmit and receive counters
// - base clock by select field, gated by power
// - transmit counter held zero unless power and enable
// - transmit counter cleared on each character write while idle
// - receive counter held zero, counts after start
// - receive counter idles after frame until start
// - divisor field sets k, valid 8 to 31
// - bit rate is base clock over 2k
// - counter sets bit latch point after start
// - overrun character is not moved to buffer
// - parity fault does not abort the frame
// - exactly one stop bit is checked
// - resample after k ticks, start if still low
module urxb_top
    import urxb_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [URXB_DW-1:0] pwdata,
    output logic      [URXB_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              serial_in,
    output logic                   serial_out,
    output logic                   rx_done_irq,
    output logic                   rx_error_irq,
    output logic                   tx_done_irq
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} urxb_rx_e;

    urxb_mode_s   mode_r;
    logic [7:0]   baud_control_r;
    urxb_err_s    err_r;
    logic [7:0]   rx_buffer_r;
    logic         rx_full_r;
    logic [3:0]   pre_r;
    logic         samp_a_r;
    logic         samp_b_r;
    logic         filt_r;
    logic         filt_d_r;
    urxb_rx_e     rx_st_r;
    logic [4:0]   rx_cnt_r;
    logic         rx_half_r;
    logic [3:0]   rx_idx_r;
    logic [8:0]   rx_shift_reg_r;
    logic [4:0]   tx_cnt_r;
    logic         tx_half_r;
    logic         tx_busy_r;
    logic [3:0]   tx_left_r;
    logic [11:0]  tx_shift_reg_r;
    logic [URXB_DW-1:0] prdata_r;
    logic         pready_r;
    logic         pslverr_r;
    logic         serial_out_r;
    logic         rx_done_r;
    logic         rx_err_irq_r;
    logic         tx_done_r;

    // bus decode
    wire logic [7:0] ofs     = paddr[7:0];
    wire logic hit_mode      = ofs == URXB_OFS_MODE;
    wire logic hit_baud      = ofs == URXB_OFS_BAUD;
    wire logic hit_err       = ofs == URXB_OFS_ERR;
    wire logic hit_rxb       = ofs == URXB_OFS_RXB;
    wire logic hit_tx        = ofs == URXB_OFS_TX;
    wire logic hit_any       = hit_mode | hit_baud | hit_err | hit_rxb | hit_tx;
    // one wait state so read data comes from a flip-flop
    wire logic acc_first     = psel & penable & ~pready_r;
    wire logic acc_done      = psel & penable & pready_r;
    wire logic wr_mode       = acc_done & pwrite & hit_mode;
    wire logic wr_baud       = acc_done & pwrite & hit_baud;
    wire logic wr_tx         = acc_done & pwrite & hit_tx;
    wire logic rd_err        = acc_done & ~pwrite & hit_err;
    wire logic rd_rxb        = acc_done & ~pwrite & hit_rxb;

    wire logic [URXB_DW-1:0] rd_mux =
        hit_mode ? {24'h000000, mode_r} :
        hit_baud ? {24'h000000, baud_control_r} :
        hit_err  ? {29'h00000000, err_r} :
        hit_rxb  ? {24'h000000, rx_buffer_r} :
        hit_tx   ? {29'h00000000, rx_full_r, rx_st_r != RX_IDLE, tx_busy_r} :
                   URXB_ZERO;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= URXB_ZERO;
        end else begin
            pready_r  <= acc_first;
            pslverr_r <= acc_first & ~hit_any;
            prdata_r  <= acc_first ? rd_mux : URXB_ZERO;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mode_r         <= URXB_MODE_RST;
            baud_control_r <= URXB_BAUD_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= urxb_mode_s'(pwdata[7:0]);
            end
            if (wr_baud) begin
                baud_control_r <= pwdata[7:0];
            end
        end
    end

    // base clock enable: divide by 2, 4, 8 or 16; held off without power
    wire logic [1:0] sel     = baud_control_r[URXB_BAUD_SEL +: 2];
    wire logic [3:0] sel_msk = 4'hF >> (2'h3 - sel);
    wire logic base_en       = mode_r.power & ((pre_r & sel_msk) == sel_msk);
    // values below 8 are out of range; treated as 8
    wire logic [4:0] div_f   = baud_control_r[URXB_BAUD_DIV +: 5];
    wire logic [4:0] k_last  = (div_f < URXB_DIV_MIN) ? 5'h07 : div_f - 5'h01;

    always_ff @(posedge clk_sys) begin
        if (!rstn || !mode_r.power) begin
            pre_r <= 4'h0;
        end else begin
            pre_r <= pre_r + 4'h1;
        end
    end

    // noise filter: line is taken on base ticks, passes when two agree
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            samp_a_r <= 1'b1;
            samp_b_r <= 1'b1;
            filt_r   <= 1'b1;
            filt_d_r <= 1'b1;
        end else if (base_en) begin
            samp_a_r <= serial_in;
            samp_b_r <= samp_a_r;
            if (samp_a_r == samp_b_r) begin
                filt_r <= samp_b_r;
            end
            filt_d_r <= filt_r;
        end
    end

    // receive side
    wire logic rx_on     = mode_r.power & mode_r.rx_en;
    wire logic rx_tick   = base_en & (rx_cnt_r == k_last);
    wire logic par_on    = mode_r.par != URXB_PAR_NONE;
    wire logic [3:0] n_dp = (mode_r.len8 ? 4'd8 : 4'd7) + {3'b000, par_on};
    wire logic [7:0] rx_data = mode_r.len8 ? rx_shift_reg_r[7:0]
                                           : {1'b0, rx_shift_reg_r[6:0]};
    wire logic rx_pbit   = mode_r.len8 ? rx_shift_reg_r[8] : rx_shift_reg_r[7];
    wire logic par_odd   = ^rx_data ^ rx_pbit;
    wire logic bit_mid   = rx_st_r == RX_BITS && rx_tick && rx_half_r;
    // only one stop bit is looked at; a second one is treated as idle line
    wire logic at_stop   = bit_mid && rx_idx_r == n_dp;
    // zero parity and no parity never flag
    wire logic par_bad   = (mode_r.par == URXB_PAR_EVEN &&  par_odd) ||
                           (mode_r.par == URXB_PAR_ODD  && !par_odd);
    wire urxb_err_s err_set = at_stop ? urxb_err_s'{parity:  par_bad,
                                                    framing: ~filt_r,
                                                    overrun: rx_full_r}
                                      : urxb_err_s'(3'h0);

    always_ff @(posedge clk_sys) begin
        if (!rstn || !rx_on) begin
            rx_st_r   <= RX_IDLE;
            rx_cnt_r  <= 5'h00;
            rx_half_r <= 1'b0;
            rx_idx_r  <= 4'h0;
        end else if (base_en) begin
            unique case (rx_st_r)
                RX_IDLE: begin
                    rx_cnt_r <= 5'h00;
                    if (filt_d_r && !filt_r) begin
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    rx_cnt_r <= rx_tick ? 5'h00 : rx_cnt_r + 5'h01;
                    if (rx_tick) begin
                        rx_st_r   <= filt_r ? RX_IDLE : RX_BITS;
                        rx_half_r <= 1'b0;
                        rx_idx_r  <= 4'h0;
                    end
                end
                RX_BITS: begin
                    rx_cnt_r <= rx_tick ? 5'h00 : rx_cnt_r + 5'h01;
                    if (rx_tick) begin
                        rx_half_r <= ~rx_half_r;
                    end
                    if (bit_mid) begin
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (at_stop) begin
                            rx_st_r <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_shift_reg_r <= 9'h000;
        end else if (bit_mid && rx_idx_r < n_dp) begin
            rx_shift_reg_r[rx_idx_r] <= filt_r;
        end
    end

    // flags: a new fault in the read cycle survives the clear
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            err_r        <= '{default: 1'b0};
            rx_full_r    <= 1'b0;
            rx_buffer_r  <= 8'h00;
            rx_done_r    <= 1'b0;
            rx_err_irq_r <= 1'b0;
        end else begin
            err_r        <= (rd_err ? urxb_err_s'(3'h0) : err_r) | err_set;
            rx_err_irq_r <= |err_set;
            rx_done_r    <= at_stop;
            if (at_stop && !rx_full_r) begin
                rx_buffer_r <= rx_data;
                rx_full_r   <= 1'b1;
            end else if (rd_rxb) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // transmit side
    wire logic tx_on   = mode_r.power & mode_r.tx_en;
    wire logic tx_tick = base_en & (tx_cnt_r == k_last);
    wire logic tx_bend = tx_tick & tx_half_r;
    wire logic tx_load = wr_tx & tx_on & ~tx_busy_r;
    wire logic tx_pbit = (mode_r.par == URXB_PAR_EVEN) ?  ^pwdata[7:0] & mode_r.len8 |
                                                          ^pwdata[6:0] & ~mode_r.len8 :
                         (mode_r.par == URXB_PAR_ODD)  ? ~(mode_r.len8 ? ^pwdata[7:0]
                                                                       : ^pwdata[6:0]) :
                         1'b0;

    function automatic logic [11:0] frame_build(input logic [7:0] d, input logic p,
                                                input logic l8, input logic pe);
        logic [11:0] f;
        f = 12'hFFF;
        f[0] = 1'b0;
        f[7:1] = d[6:0];
        if (l8) begin
            f[8] = d[7];
        end
        if (pe) begin
            f[l8 ? 9 : 8] = p;
        end
        return f;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!rstn || !tx_on) begin
            tx_cnt_r  <= 5'h00;
            tx_half_r <= 1'b0;
        end else if (tx_load) begin
            tx_cnt_r  <= 5'h00;
            tx_half_r <= 1'b0;
        end else if (base_en) begin
            tx_cnt_r <= tx_tick ? 5'h00 : tx_cnt_r + 5'h01;
            if (tx_tick) begin
                tx_half_r <= ~tx_half_r;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn || !tx_on) begin
            tx_busy_r      <= 1'b0;
            tx_left_r      <= 4'h0;
            tx_shift_reg_r <= 12'hFFF;
            tx_done_r      <= 1'b0;
        end else begin
            tx_done_r <= tx_busy_r & tx_bend & (tx_left_r == 4'h1);
            if (tx_load) begin
                tx_busy_r      <= 1'b1;
                tx_shift_reg_r <= frame_build(pwdata[7:0], tx_pbit, mode_r.len8, par_on);
                tx_left_r      <= n_dp + 4'd2 + {3'b000, mode_r.stop2};
            end else if (tx_busy_r && tx_bend) begin
                tx_shift_reg_r <= {1'b1, tx_shift_reg_r[11:1]};
                tx_left_r      <= tx_left_r - 4'h1;
                tx_busy_r      <= tx_left_r != 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            serial_out_r <= 1'b1;
        end else begin
            serial_out_r <= tx_busy_r ? tx_shift_reg_r[0] : 1'b1;
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign serial_out   = serial_out_r;
    assign rx_done_irq  = rx_done_r;
    assign rx_error_irq = rx_err_irq_r;
    assign tx_done_irq  = tx_done_r;
endmodule

// [tb/urxb_properties.sv]
// checker: port-level properties of the serial unit
`timescale 1ns/1ps
module urxb_properties
    import urxb_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic                clk_sys,
    input wire logic                rstn,
    input wire logic [AW-1:0]       paddr,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [URXB_DW-1:0]  pwdata,
    input wire logic [URXB_DW-1:0]  prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                serial_in,
    input wire logic                serial_out,
    input wire logic                rx_done_irq,
    input wire logic                rx_error_irq,
    input wire logic                tx_done_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_err_read;
        pready && !pwrite && paddr == URXB_OFS_ERR;
    endsequence
    a_ready_follows: assert property (s_access |=> pready)
        else $error("access not answered in one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");
    a_rdata_idle: assert property (!pready |-> prdata == URXB_ZERO)
        else $error("read data outside answer cycle");
    a_err_width: assert property (s_err_read |-> prdata[31:3] == 29'h0)
        else $error("status read shows bits above the three flags");
    a_err_with_done: assert property (rx_error_irq |-> rx_done_irq)
        else $error("error request without frame completion");
    a_err_pulse: assert property (rx_error_irq |=> !rx_error_irq)
        else $error("error request longer than one cycle");
    a_done_gap: assert property (rx_done_irq |=> !rx_done_irq [*8])
        else $error("receiver completed frames too close together");
    a_reset_quiet: assert property ($rose(rstn) |-> serial_out && !pready && !rx_error_irq)
        else $error("outputs not quiet after reset");
endmodule
bind urxb_top urxb_properties #(.AW(AW)) chk_u (.clk_sys(clk_sys), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
    .serial_out(serial_out), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq),
    .tx_done_irq(tx_done_irq));

// [tb/urxb_remote.sv]
// partner: remote transmitter driving the serial line
`timescale 1ns/1ps
module urxb_remote (
    input wire logic clk_sys,
    output logic     serial_in
);
    initial serial_in = 1'b1;
    task automatic bit_out(input logic v, input int bitc);
        serial_in <= v;
        repeat (bitc) @(posedge clk_sys);
    endtask
    // exact rate, so always inside the receiver tolerance
    task automatic send(input logic [7:0] d, input logic pe, input logic pb,
                        input logic sb, input int bitc);
        bit_out(1'b0, bitc);
        for (int i = 0; i < 8; i++) begin
            bit_out(d[i], bitc);
        end
        if (pe) begin
            bit_out(pb, bitc);
        end
        bit_out(sb, bitc);
        bit_out(1'b1, bitc);
    endtask
    task automatic glitch(input int n);
        bit_out(1'b0, n);
        bit_out(1'b1, 1);
    endtask
endmodule

// [tb/urxb_top_bench.sv]
// testbench: receive faults, filter and baud generator of the serial unit
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module urxb_top_bench;
    import urxb_pkg::*;
    localparam int BITC = 32; // base = clk/2, k = 8
    logic        clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, last_err;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0, prdata, rd_v;
    logic        pready, pslverr, serial_in, serial_out, rx_done_irq, rx_error_irq, tx_done_irq;
    int          failures = 0, comparisons = 0, n_done = 0, n_err = 0, n_tx = 0;
    int          run = 0, nrun = 0;
    int          runs[4];
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_done += int'(rx_done_irq === 1'b1);
        n_err  += int'(rx_error_irq === 1'b1);
        n_tx   += int'(tx_done_irq === 1'b1);
        if (serial_out === 1'b0) begin
            run++;
        end else if (run != 0) begin
            if (nrun < 4) runs[nrun] = run;
            nrun++;
            run = 0;
        end
    end
    urxb_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
        .serial_out(serial_out), .rx_done_irq(rx_done_irq),
        .rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq));
    urxb_remote rem_u (.clk_sys(clk_sys), .serial_in(serial_in));
    task end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no cycle count assumed; a hung slave is left to the watchdog
        do begin @(posedge clk_sys); end while (pready !== 1'b1);
        rd_v = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // one frame in, then status and buffer read as an error handler would
    task automatic frame(input logic [7:0] d, input logic pe, input logic pb, input logic sb,
                         input logic [2:0] ee, input logic [7:0] eb);
        int d0, e0;
        d0 = n_done; e0 = n_err;
        rem_u.send(d, pe, pb, sb, BITC);
        `CHK(n_done - d0, 1)
        `CHK(n_err - e0, int'(ee != 3'h0))
        apb(URXB_OFS_ERR, 1'b0, 32'h0); `CHK(rd_v, {29'h0, ee})
        apb(URXB_OFS_RXB, 1'b0, 32'h0); `CHK(rd_v, {24'h0, eb})
    endtask
    task t_regs;
        apb(URXB_OFS_MODE, 1'b0, 32'h0); `CHK(rd_v, {24'h0, URXB_MODE_RST})
        apb(URXB_OFS_BAUD, 1'b0, 32'h0); `CHK(rd_v, {24'h0, URXB_BAUD_RST})
        apb(URXB_OFS_ERR, 1'b0, 32'h0); `CHK(rd_v, URXB_ZERO)
        apb(8'h14, 1'b0, 32'h0); `CHK(last_err, 1'b1)
        apb(URXB_OFS_MODE, 1'b1, 32'hA4); apb(URXB_OFS_MODE, 1'b0, 32'h0);
        `CHK(rd_v, 32'h0000_00A4)
    endtask
    task t_good_parity;
        logic [1:0] par;
        frame(8'hA5, 1'b0, 1'b0, 1'b1, 3'h0, 8'hA5);
        for (int p = 1; p < 4; p++) begin
            par = p[1:0];
            apb(URXB_OFS_MODE, 1'b1, {24'h0, 8'hA4 | {3'h0, par, 3'h0}});
            for (int b = 0; b < 2; b++) begin
                frame(8'h3C, 1'b1, b[0], 1'b1,
                      ((par == 2'h2 && b == 0) || (par == 2'h3 && b == 1)) ? 3'h4 : 3'h0,
                      8'h3C);
            end
        end
        // 7-bit even parity: top bit of the remote byte is the parity bit
        apb(URXB_OFS_MODE, 1'b1, 32'hB8);
        frame(8'hB6, 1'b0, 1'b0, 1'b1, 3'h4, 8'h36);
        apb(URXB_OFS_ERR, 1'b0, 32'h0); `CHK(rd_v, URXB_ZERO)
    endtask
    task t_frame_overrun;
        apb(URXB_OFS_MODE, 1'b1, 32'hA4);
        frame(8'h3C, 1'b0, 1'b0, 1'b0, 3'h2, 8'h3C);
        rem_u.send(8'hA5, 1'b0, 1'b0, 1'b1, BITC);
        frame(8'h5A, 1'b0, 1'b0, 1'b1, 3'h1, 8'hA5);
    endtask
    task t_filter_power;
        int d0;
        d0 = n_done;
        rem_u.glitch(1);
        rem_u.glitch(12);
        repeat (300) @(posedge clk_sys);
        `CHK(n_done - d0, 0)
        apb(URXB_OFS_TX, 1'b0, 32'h0); `CHK(rd_v[1], 1'b0)
        apb(URXB_OFS_MODE, 1'b1, 32'h24);
        rem_u.send(8'hA5, 1'b0, 1'b0, 1'b1, BITC);
        `CHK(n_done - d0, 0)
    endtask
    task t_tx;
        int t0, n;
        apb(URXB_OFS_BAUD, 1'b1, 32'h49); // base = clk/4, k = 9
        apb(URXB_OFS_MODE, 1'b1, 32'hC4);
        repeat (8) @(posedge clk_sys);
        t0 = n_tx; n = 0; nrun = 0;
        apb(URXB_OFS_TX, 1'b1, 32'h01);
        while (n_tx == t0 && n < 2000) begin @(posedge clk_sys); n++; end
        `CHK(n_tx - t0, 1)
        `CHK(runs[0], 72)
        `CHK(runs[1], 504)
        apb(URXB_OFS_MODE, 1'b1, 32'h84);
        apb(URXB_OFS_TX, 1'b1, 32'h01);
        repeat (100) @(posedge clk_sys);
        `CHK(nrun, 2)
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_regs;
        t_good_parity;
        t_frame_overrun;
        t_filter_power;
        t_tx;
        end_of_test;
    end
    initial begin
        #100000;
        failures++;
        end_of_test;
    end
endmodule
